// ===== hdl/ectp_consts.svh
// offsets, field positions, reset values and edge codes of the event count / trigger pwm timer
// assumes a byte-addressed register port with one aligned 32-bit word per register
`ifndef ECTP_CONSTS_SVH
`define ECTP_CONSTS_SVH

`define ECTP_ADDR_W        8
`define ECTP_DATA_W        32
`define ECTP_CNT_W         16

`define ECTP_OFS_CTRL0     8'h00
`define ECTP_OFS_CTRL1     8'h04
`define ECTP_OFS_IOCTL     8'h08
`define ECTP_OFS_EDGE      8'h0C
`define ECTP_OFS_MASK      8'h10
`define ECTP_OFS_CMP0      8'h14
`define ECTP_OFS_CMP1      8'h18
`define ECTP_OFS_CMP2      8'h1C
`define ECTP_OFS_CMP3      8'h20
`define ECTP_OFS_COUNT     8'h24
`define ECTP_OFS_OPTION    8'h28

`define ECTP_BIT_ENABLE    0
`define ECTP_MODE_LSB      0
`define ECTP_BIT_EVCLK     5
`define ECTP_BIT_SWTRIG    6
`define ECTP_EV_EDGE_LSB   2
`define ECTP_TR_EDGE_LSB   0
`define ECTP_MASK_LSB      1

`define ECTP_CNT_CLEAR     16'h0000
`define ECTP_CNT_IDLE      16'hFFFF
`define ECTP_CMP_RST       16'h0000

`define ECTP_EDGE_NONE     2'h0
`define ECTP_EDGE_RISE     2'h1
`define ECTP_EDGE_FALL     2'h2
`define ECTP_EDGE_BOTH     2'h3

`endif

// ===== hdl/ectp_pkg.sv
// types of the event count / trigger pwm timer
// assumes ectp_consts.svh for all numeric constants except the mode codes, which are given here
package ectp_pkg;
    typedef enum logic [2:0] {
        ECTP_MODE_INTERVAL = 3'h0,
        ECTP_MODE_EVENT    = 3'h1,
        ECTP_MODE_TRIGGER  = 3'h2
    } ectp_mode_t;

    typedef enum logic [1:0] {
        ECTP_ST_IDLE,
        ECTP_ST_WAIT,
        ECTP_ST_RUN
    } ectp_state_t;
endpackage

// ===== hdl/ectp_timer.sv
// 16-bit timer in external event count mode and trigger pwm output mode
// assumes one 20 MHz clock as the count clock, pins asynchronous, single-cycle register strobes
`timescale 1ns/1ns
`include "ectp_consts.svh"

// Contract
// - event mode: counter clears and period event fires after period value + 1 edges
// - event mode: channel compare writes go straight to the buffers, events fire on counter equality
// - event mode keeps every timer output disabled
// - period FFFF: count to FFFF, wrap to 0000 with period event, no overflow
// - period write in event mode hits buffer at once; counter may wrap past FFFF
// - channel value below period: one channel event per counter cycle
// - channel value above period: channel event never fires
// - trigger mode: enable makes the timer wait for a trigger, not count
// - trigger clears counter to 0000 and starts it; retrigger restarts it
// - trigger inverts channel 0 output and drives pwm outputs high
// - pwm active for channel value clocks within period value + 1 clocks
// - trigger mode: period event and clear on the count after equality
// - channel event fires when counter equals that channel's buffered value
// - trigger mode: all compare values copied to buffers at period match
// - trigger is an external valid edge or software writing the trigger bit
// - software triggering gives channel 0 a square wave, half period one pwm period
// - mode field 001 selects event count mode
// - enable in event mode clears counter, loads period buffer; edges then count
module ectp_timer
    import ectp_pkg::*;
(
    // clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    nrst_in,
    // register port
    input  wire logic [`ECTP_ADDR_W-1:0] reg_addr_in,
    input  wire logic [`ECTP_DATA_W-1:0] reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    output logic      [`ECTP_DATA_W-1:0] reg_rdata_out,
    // pins
    input  wire logic                    event_pin_in,
    input  wire logic                    trigger_pin_in,
    output logic      [3:0]              timer_out,
    output logic      [3:0]              timer_oe_out,
    // match events
    output logic                         period_match_event_out,
    output logic      [3:1]              channel_match_event_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // registers and state
    logic                    count_enable_bit_ff;
    logic [2:0]              mode_ff;
    logic                    event_clock_select_bit_ff;
    logic [3:0]              out_enable_ff;
    logic [3:0]              edge_sel_ff;
    logic [3:1]              channel_event_mask_ff;
    logic [`ECTP_CNT_W-1:0]  cmp_reg_ff [0:3];
    logic [`ECTP_CNT_W-1:0]  cmp_buf_ff [0:3];
    logic [`ECTP_CNT_W-1:0]  cnt_ff;
    ectp_state_t             state_ff;
    logic [2:0]              ev_sync_ff;
    logic [2:0]              tr_sync_ff;
    logic [3:0]              out_ff;
    logic                    period_evt_ff;
    logic [3:1]              ch_evt_ff;
    logic [`ECTP_DATA_W-1:0] rdata_ff;

    logic                    wr_ctrl0;
    logic                    start;
    logic                    ev_edge;
    logic                    tr_edge;
    logic                    sw_trig;
    logic                    trig;
    logic                    tick;
    logic                    period_hit;
    logic                    is_event;
    logic                    is_trigger;
    logic [`ECTP_CNT_W-1:0]  nxt_cnt;
    logic [`ECTP_CNT_W-1:0]  nxt_buf [0:3];

    function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
        case (sel)
            `ECTP_EDGE_RISE: edge_hit = cur & ~prev;
            `ECTP_EDGE_FALL: edge_hit = ~cur & prev;
            `ECTP_EDGE_BOTH: edge_hit = cur ^ prev;
            default:         edge_hit = 1'b0;
        endcase
    endfunction

    assign is_event   = (mode_ff == ECTP_MODE_EVENT);
    assign is_trigger = (mode_ff == ECTP_MODE_TRIGGER);
    assign wr_ctrl0   = reg_wr_in & (reg_addr_in == `ECTP_OFS_CTRL0);
    assign start      = wr_ctrl0 & reg_wdata_in[`ECTP_BIT_ENABLE] & ~count_enable_bit_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; edges only looked at on stages 1 and 2
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ev_sync_ff <= 3'h0;
            tr_sync_ff <= 3'h0;
        end else begin
            ev_sync_ff <= {ev_sync_ff[1:0], event_pin_in};
            tr_sync_ff <= {tr_sync_ff[1:0], trigger_pin_in};
        end
    end

    assign ev_edge = edge_hit(edge_sel_ff[`ECTP_EV_EDGE_LSB +: 2], ev_sync_ff[1], ev_sync_ff[2]);
    assign tr_edge = edge_hit(edge_sel_ff[`ECTP_TR_EDGE_LSB +: 2], tr_sync_ff[1], tr_sync_ff[2]);
    assign sw_trig = reg_wr_in & (reg_addr_in == `ECTP_OFS_CTRL1) & reg_wdata_in[`ECTP_BIT_SWTRIG];
    // a trigger counts only once the enable is in and the timer is waiting or running
    assign trig    = is_trigger & (state_ff != ECTP_ST_IDLE) & (tr_edge | sw_trig);

    ////////////////////////////////////////////////////////////////////////////////
    // count step, period match and buffer next values
    always_comb begin
        tick = 1'b0;
        if (state_ff == ECTP_ST_RUN) begin
            tick = is_event ? ev_edge : 1'b1;
        end
        period_hit = tick & (cnt_ff == cmp_buf_ff[0]);
        nxt_cnt    = cnt_ff;
        if (start) begin
            nxt_cnt = is_event ? `ECTP_CNT_CLEAR : `ECTP_CNT_IDLE;
        end else if (trig) begin
            nxt_cnt = `ECTP_CNT_CLEAR;
        end else if (period_hit) begin
            nxt_cnt = `ECTP_CNT_CLEAR;
        end else if (tick) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
        for (int m = 0; m < 4; m++) begin
            nxt_buf[m] = cmp_buf_ff[m];
            if (start || (period_hit && is_trigger)) begin
                nxt_buf[m] = cmp_reg_ff[m];
            end
            // event mode compares take a write at once, even mid-count
            if (is_event && reg_wr_in && reg_addr_in == `ECTP_OFS_CMP0 + 8'(4 * m)) begin
                nxt_buf[m] = reg_wdata_in[`ECTP_CNT_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_enable_bit_ff       <= 1'b0;
            mode_ff                   <= 3'h0;
            event_clock_select_bit_ff <= 1'b0;
            out_enable_ff             <= 4'h0;
            edge_sel_ff               <= 4'h0;
            channel_event_mask_ff     <= 3'h0;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `ECTP_OFS_CTRL0: count_enable_bit_ff <= reg_wdata_in[`ECTP_BIT_ENABLE];
                `ECTP_OFS_CTRL1: begin
                    mode_ff                   <= reg_wdata_in[`ECTP_MODE_LSB +: 3];
                    event_clock_select_bit_ff <= reg_wdata_in[`ECTP_BIT_EVCLK];
                end
                `ECTP_OFS_IOCTL: out_enable_ff         <= reg_wdata_in[3:0];
                `ECTP_OFS_EDGE:  edge_sel_ff           <= reg_wdata_in[3:0];
                `ECTP_OFS_MASK:  channel_event_mask_ff <= reg_wdata_in[`ECTP_MASK_LSB +: 3];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int m = 0; m < 4; m++) begin
                cmp_reg_ff[m] <= `ECTP_CMP_RST;
            end
        end else begin
            for (int m = 0; m < 4; m++) begin
                if (reg_wr_in && reg_addr_in == `ECTP_OFS_CMP0 + 8'(4 * m)) begin
                    cmp_reg_ff[m] <= reg_wdata_in[`ECTP_CNT_W-1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // run state, counter and compare buffers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= ECTP_ST_IDLE;
        end else if (wr_ctrl0 && !reg_wdata_in[`ECTP_BIT_ENABLE]) begin
            state_ff <= ECTP_ST_IDLE;
        end else begin
            case (state_ff)
                ECTP_ST_IDLE: if (start) state_ff <= is_trigger ? ECTP_ST_WAIT : ECTP_ST_RUN;
                ECTP_ST_WAIT: if (trig) state_ff <= ECTP_ST_RUN;
                ECTP_ST_RUN:  state_ff <= ECTP_ST_RUN;
                default:      state_ff <= ECTP_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_ff <= `ECTP_CNT_IDLE;
            for (int m = 0; m < 4; m++) begin
                cmp_buf_ff[m] <= `ECTP_CMP_RST;
            end
        end else begin
            cnt_ff <= nxt_cnt;
            for (int m = 0; m < 4; m++) begin
                cmp_buf_ff[m] <= nxt_buf[m];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // match events, one-cycle pulses
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            period_evt_ff <= 1'b0;
            ch_evt_ff     <= 3'h0;
        end else begin
            period_evt_ff <= period_hit;
            for (int k = 1; k < 4; k++) begin
                // only a counter step into the value fires, so at most once per cycle
                ch_evt_ff[k] <= (tick | trig) & (nxt_cnt == nxt_buf[k]) & ~channel_event_mask_ff[k];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // waveform outputs
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            out_ff <= 4'h0;
        end else if (!is_trigger) begin
            out_ff <= 4'h0;
        end else begin
            if (trig || period_hit) begin
                out_ff[0] <= ~out_ff[0];
            end
            for (int k = 1; k < 4; k++) begin
                if (trig) begin
                    out_ff[k] <= 1'b1;
                end else if (tick) begin
                    out_ff[k] <= (nxt_cnt < nxt_buf[k]);
                end
            end
        end
    end

    assign timer_out    = out_ff;
    assign timer_oe_out = is_trigger ? out_enable_ff : 4'h0;

    assign period_match_event_out  = period_evt_ff;
    assign channel_match_event_out = ch_evt_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe; overflow never sets in these modes
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_ff <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `ECTP_OFS_CTRL0:  rdata_ff <= {31'h0, count_enable_bit_ff};
                `ECTP_OFS_CTRL1:  rdata_ff <= {26'h0, event_clock_select_bit_ff, 2'h0, mode_ff};
                `ECTP_OFS_IOCTL:  rdata_ff <= {28'h0, out_enable_ff};
                `ECTP_OFS_EDGE:   rdata_ff <= {28'h0, edge_sel_ff};
                `ECTP_OFS_MASK:   rdata_ff <= {28'h0, channel_event_mask_ff, 1'b0};
                `ECTP_OFS_CMP0:   rdata_ff <= {16'h0, cmp_reg_ff[0]};
                `ECTP_OFS_CMP1:   rdata_ff <= {16'h0, cmp_reg_ff[1]};
                `ECTP_OFS_CMP2:   rdata_ff <= {16'h0, cmp_reg_ff[2]};
                `ECTP_OFS_CMP3:   rdata_ff <= {16'h0, cmp_reg_ff[3]};
                `ECTP_OFS_COUNT:  rdata_ff <= {16'h0, cnt_ff};
                `ECTP_OFS_OPTION: rdata_ff <= 32'h0000_0000;
                default:          rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign reg_rdata_out = rdata_ff;

endmodule

// ===== sim/ectp_pins_model.sv
// event and trigger sources in front of the timer pins
// assumes the bench holds count and gap steady while busy
`timescale 1ns/1ns
module ectp_pins_model (
    // clock
    input  wire logic       clk_in,
    // commands
    input  wire logic       ev_go_in,
    input  wire logic       trig_go_in,
    input  wire logic [7:0] count_in,
    input  wire logic [3:0] gap_in,
    // pins
    output logic            event_pin_out,
    output logic            trigger_pin_out,
    output logic            busy_out
);
    initial begin
        event_pin_out = 1'b0;
        trigger_pin_out = 1'b0;
        busy_out = 1'b0;
    end
    // pin choice and count latched at the command, the go strobe drops after one cycle
    logic       ev_mode;
    logic [7:0] n_left;
    // each level held gap clocks, long enough for the pin synchroniser
    always begin
        @(posedge clk_in);
        if (ev_go_in === 1'b1 || trig_go_in === 1'b1) begin
            ev_mode = ev_go_in;
            n_left  = ev_go_in ? count_in : 8'h01;
            busy_out <= 1'b1;
            repeat (n_left) begin
                if (ev_mode) event_pin_out <= 1'b1;
                else trigger_pin_out <= 1'b1;
                repeat (gap_in) @(posedge clk_in);
                event_pin_out <= 1'b0;
                trigger_pin_out <= 1'b0;
                repeat (gap_in) @(posedge clk_in);
            end
            busy_out <= 1'b0;
        end
    end
endmodule

// ===== sim/ectp_timer_sva.sv
// checker of the event count / trigger pwm timer, ports only
// assumes the register shadows below follow every software write
`timescale 1ns/1ns
`include "ectp_consts.svh"
module ectp_timer_sva (
    // clock and reset
    input wire logic        clk_in,
    input wire logic        nrst_in,
    // register port
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // pins and events
    input wire logic        event_pin_in,
    input wire logic        trigger_pin_in,
    input wire logic [3:0]  timer_out,
    input wire logic [3:0]  timer_oe_out,
    input wire logic        period_match_event_out,
    input wire logic [3:1]  channel_match_event_out
);
    logic [2:0]  mode_ff;
    logic        en_ff;
    logic [3:1]  mask_ff;
    logic [15:0] c0_ff;
    logic [15:0] c2_ff;
    logic        trig_wr;
    logic        en_wr;
    assign trig_wr = reg_wr_in && reg_addr_in == `ECTP_OFS_CTRL1 && reg_wdata_in[6] && reg_wdata_in[2:0] == 3'h2;
    assign en_wr   = reg_wr_in && reg_addr_in == `ECTP_OFS_CTRL0 && reg_wdata_in[0];
    ////////////////////////////////////////////////////////////////////////
    // shadows rebuilt from writes, so no internal probing is needed
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_ff <= 3'h0;
            en_ff   <= 1'b0;
            mask_ff <= 3'h0;
            c0_ff   <= 16'h0000;
            c2_ff   <= 16'h0000;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `ECTP_OFS_CTRL1: mode_ff <= reg_wdata_in[2:0];
                `ECTP_OFS_CTRL0: en_ff <= reg_wdata_in[0];
                `ECTP_OFS_MASK:  mask_ff <= reg_wdata_in[3:1];
                `ECTP_OFS_CMP0:  c0_ff <= reg_wdata_in[15:0];
                `ECTP_OFS_CMP2:  c2_ff <= reg_wdata_in[15:0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    AST_OE_EVENT: assert property ((mode_ff == 3'h1) |-> (timer_oe_out == 4'h0))
        else $error("output enable set in event mode");
    AST_OUT_EVENT: assert property ((mode_ff == 3'h1 && $past(mode_ff) == 3'h1) |-> (timer_out == 4'h0))
        else $error("timer output moved in event mode");
    AST_OVF_ZERO: assert property ((reg_rd_in && reg_addr_in == `ECTP_OFS_OPTION) |=> (reg_rdata_out == 32'h0))
        else $error("overflow flag read as set");
    AST_PERIOD_PULSE: assert property (period_match_event_out |=> !period_match_event_out)
        else $error("period event longer than one cycle");
    AST_SW_TRIG_HIGH: assert property ((trig_wr && mode_ff == 3'h2 && en_ff) |-> ##[1:2] (timer_out[3:1] == 3'h7))
        else $error("pwm outputs not high after trigger");
    AST_TRIG_WAIT: assert property ((en_wr && !en_ff && mode_ff == 3'h2) |=> (!period_match_event_out) [*8])
        else $error("period event while waiting for trigger");
    AST_IDLE_QUIET: assert property ((!en_ff && !$past(en_ff) && !$past(en_ff, 2))
        |-> (!period_match_event_out && channel_match_event_out == 3'h0))
        else $error("event while counting stopped");
    AST_MASK_GATE: assert property ($stable(mask_ff) |-> ((channel_match_event_out & mask_ff) == 3'h0))
        else $error("masked channel event seen");
    AST_CH_ABOVE: assert property ((mode_ff == 3'h1 && en_ff && c2_ff > c0_ff && $past(c2_ff > c0_ff))
        |-> !channel_match_event_out[2])
        else $error("channel event above period value");
endmodule
bind ectp_timer ectp_timer_sva i_ectp_timer_sva (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .event_pin_in(event_pin_in), .trigger_pin_in(trigger_pin_in), .timer_out(timer_out),
    .timer_oe_out(timer_oe_out), .period_match_event_out(period_match_event_out),
    .channel_match_event_out(channel_match_event_out));

// ===== sim/test_ectp_timer.sv
// self-checking bench of the event count / trigger pwm timer
// assumes a 20 MHz clock and the register map of ectp_consts.svh
`timescale 1ns/1ns
`include "ectp_consts.svh"
module test_ectp_timer;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic        event_pin_in;
    logic        trigger_pin_in;
    logic [3:0]  timer_out;
    logic [3:0]  timer_oe_out;
    logic        period_match_event_out;
    logic [3:1]  channel_match_event_out;
    logic        ev_go = 1'b0;
    logic        trig_go = 1'b0;
    logic        busy;
    logic        last0 = 1'b0;
    logic [7:0]  n_edges = 8'h00;
    logic [3:0]  gap = 4'h3;
    logic [31:0] v;
    int          n_fail = 0;
    int          total_checks = 0;
    int          n_per = 0;
    int          n_tog = 0;
    int          n_ch [1:3];
    int          n_hi [1:3];
    always #25 clk_in = ~clk_in;
    ectp_timer i_ectp_timer (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .event_pin_in(event_pin_in), .trigger_pin_in(trigger_pin_in), .timer_out(timer_out),
        .timer_oe_out(timer_oe_out), .period_match_event_out(period_match_event_out),
        .channel_match_event_out(channel_match_event_out));
    ectp_pins_model i_ectp_pins_model (.clk_in(clk_in), .ev_go_in(ev_go), .trig_go_in(trig_go),
        .count_in(n_edges), .gap_in(gap), .event_pin_out(event_pin_in), .trigger_pin_out(trigger_pin_in),
        .busy_out(busy));
    ////////////////////////////////////////////////////////////////////////
    // event and level tallies, cleared off the edge to avoid races
    always @(posedge clk_in) begin
        if (period_match_event_out === 1'b1) n_per++;
        if (timer_out[0] !== last0) n_tog++;
        last0 = timer_out[0];
        for (int k = 1; k < 4; k++) begin
            if (channel_match_event_out[k] === 1'b1) n_ch[k]++;
            if (timer_out[k] === 1'b1) n_hi[k]++;
        end
    end
    task automatic clr;
        @(negedge clk_in);
        n_per = 0;
        n_tog = 0;
        for (int k = 1; k < 4; k++) begin
            n_ch[k] = 0;
            n_hi[k] = 0;
        end
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    // read data stand one cycle only, so they are taken mid-cycle
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        v = reg_rdata_out;
        if (exp !== 32'hFFFFFFFF) chk(v, exp);
    endtask
    task automatic edges(input logic [7:0] n, input logic trig);
        int t = 0;
        @(posedge clk_in);
        n_edges <= n;
        ev_go <= !trig;
        trig_go <= trig;
        @(posedge clk_in);
        ev_go <= 1'b0;
        trig_go <= 1'b0;
        @(posedge clk_in);
        while (busy === 1'b1 && t < 500) begin
            @(posedge clk_in);
            t++;
        end
        chk(32'(t < 500), 32'h1);
        repeat (4) @(posedge clk_in);
    endtask
    task end_sim;
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        end_sim;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'b1;
        rdc(`ECTP_OFS_COUNT, 32'h0000FFFF);
        rdc(`ECTP_OFS_OPTION, 32'h0);
        rdc(8'h30, 32'h0);
        // event mode, outputs asked for but must stay off
        wr(`ECTP_OFS_EDGE, 32'h4);
        wr(`ECTP_OFS_IOCTL, 32'hF);
        wr(`ECTP_OFS_CTRL1, 32'h1);
        wr(`ECTP_OFS_CMP0, 32'h3);
        wr(`ECTP_OFS_CMP1, 32'h1);
        wr(`ECTP_OFS_CMP2, 32'h5);
        wr(`ECTP_OFS_CMP3, 32'h2);
        wr(`ECTP_OFS_MASK, 32'h8);
        wr(`ECTP_OFS_CTRL0, 32'h1);
        rdc(`ECTP_OFS_COUNT, 32'h0);
        chk(32'(timer_oe_out), 32'h0);
        clr;
        edges(8'h03, 1'b0);
        rdc(`ECTP_OFS_COUNT, 32'h3);
        chk(n_per, 0);
        edges(8'h01, 1'b0);
        rdc(`ECTP_OFS_COUNT, 32'h0);
        chk(n_per, 1);
        chk(n_ch[1], 1);
        chk(n_ch[2], 0);
        chk(n_ch[3], 0);
        chk(32'(timer_out), 32'h0);
        // slow source; period lowered below the count on purpose
        gap = 4'h5;
        clr;
        edges(8'h02, 1'b0);
        wr(`ECTP_OFS_CMP0, 32'h1);
        edges(8'h01, 1'b0);
        rdc(`ECTP_OFS_COUNT, 32'h3);
        chk(n_per, 0);
        wr(`ECTP_OFS_CTRL0, 32'h0);
        edges(8'h02, 1'b0);
        rdc(`ECTP_OFS_COUNT, 32'h3);
        chk(n_per, 0);
        // trigger pwm mode, period 4 clocks
        gap = 4'h3;
        wr(`ECTP_OFS_CTRL1, 32'h2);
        wr(`ECTP_OFS_CMP0, 32'h3);
        wr(`ECTP_OFS_CMP1, 32'h1);
        wr(`ECTP_OFS_CMP2, 32'h2);
        wr(`ECTP_OFS_CMP3, 32'h4);
        wr(`ECTP_OFS_MASK, 32'h0);
        wr(`ECTP_OFS_EDGE, 32'h1);
        wr(`ECTP_OFS_CTRL0, 32'h1);
        repeat (10) @(posedge clk_in);
        rdc(`ECTP_OFS_COUNT, 32'h0000FFFF);
        wr(`ECTP_OFS_CTRL1, 32'h42);
        repeat (6) @(posedge clk_in);
        clr;
        repeat (8) @(posedge clk_in);
        @(negedge clk_in);
        chk(n_per, 2);
        chk(n_hi[1], 2);
        chk(n_hi[2], 4);
        chk(n_hi[3], 8);
        chk(n_ch[1], 2);
        chk(n_ch[3], 0);
        chk(n_tog, 2);
        chk(32'(timer_oe_out), 32'hF);
        rdc(`ECTP_OFS_CTRL1, 32'h2);
        // pin trigger from waiting, then a retrigger while running
        wr(`ECTP_OFS_CTRL0, 32'h0);
        wr(`ECTP_OFS_CMP0, 32'h40);
        wr(`ECTP_OFS_CTRL0, 32'h1);
        repeat (10) @(posedge clk_in);
        edges(8'h01, 1'b1);
        repeat (30) @(posedge clk_in);
        rdc(`ECTP_OFS_COUNT, 32'hFFFFFFFF);
        chk(32'(v[15:0] >= 16'h18 && v[15:0] < 16'h40), 32'h1);
        // shorter period waits in its register until the running one matches
        wr(`ECTP_OFS_CMP0, 32'h10);
        edges(8'h01, 1'b1);
        rdc(`ECTP_OFS_COUNT, 32'hFFFFFFFF);
        chk(32'(v[15:0] < 16'h18), 32'h1);
        repeat (20) @(posedge clk_in);
        rdc(`ECTP_OFS_COUNT, 32'hFFFFFFFF);
        chk(32'(v[15:0] >= 16'h18 && v[15:0] < 16'h40), 32'h1);
        end_sim;
    end
endmodule
